// ### lcs_batt.sv
/*
  Battery model and pull-ups on the open-drain indicator pins.
  Assumes lcs_pkg is compiled first and the bench drives the load.
*/
`timescale 1ns/1ps
`default_nettype none
module lcs_batt (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  // Charger side
  input  wire logic [1:0] ireq_i,
  input  wire logic       cv_i,
  input  wire logic       status_oe_i,
  input  wire logic       fault_oe_i,
  // Bench side
  input  wire logic       load_i,
  input  wire logic [7:0] load_val_i,
  // Comparators and pins
  output logic            above_min_o,
  output logic            at_final_o,
  output logic            below_rch_o,
  output logic            taper_o,
  output logic            status_pin_o,
  output logic            fault_pin_o
);
  logic [7:0] vbat_reg;
  logic [1:0] div_reg;
  // Cell voltage climbs one step every four charging cycles
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      vbat_reg <= 8'h00;
      div_reg  <= 2'h0;
    end else begin
      div_reg <= div_reg + 2'h1;
      if (load_i) begin
        vbat_reg <= load_val_i;
      end else if (ireq_i != 2'h0 && div_reg == 2'h3 && vbat_reg < 8'hC8) begin
        vbat_reg <= vbat_reg + 8'h01;
      end
    end
  end
  // Levels; current tapers once regulated at the final voltage
  assign above_min_o  = (vbat_reg >= 8'h28);
  assign at_final_o   = (vbat_reg >= 8'hC8);
  assign below_rch_o  = (vbat_reg < 8'hB9);
  assign taper_o      = at_final_o && cv_i;
  // Released pins are pulled high
  assign status_pin_o = !status_oe_i;
  assign fault_pin_o  = !fault_oe_i;
endmodule // lcs_batt
`default_nettype wire

// ### lcs_map.svh
/*
  Holds the constants of the charge sequencer: register offsets,
  field positions, reset values and timing counts.
  Assumes it is included by the package and by the design file.
*/
`ifndef LCS_MAP_SVH
`define LCS_MAP_SVH

// ----------------------------------------------------------------
// Register map (byte addresses)
// ----------------------------------------------------------------
`define LCS_CTRL_ADDR     12'h000
`define LCS_STAT_ADDR     12'h004
`define LCS_TIMER_ADDR    12'h008
`define LCS_OSCDIV_ADDR   12'h00C

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define LCS_CTRL_EN_BIT   0
`define LCS_CTRL_LIMIT_ENABLE_INPUT_BIT 1
`define LCS_CTRL_OPT_LSB  2
`define LCS_CTRL_TERM_BIT 4
`define LCS_CTRL_RESET    32'h0000_0002

// ----------------------------------------------------------------
// Timing counts
// ----------------------------------------------------------------
`define LCS_TIMER_W       22
`define LCS_TRICKLE_LIMIT 22'h080000
`define LCS_FAST_LIMIT    22'h3FFFFF
`define LCS_OSCDIV_RESET  32'h0000_0009

`endif

// ### lcs_pkg.sv
/*
  Types of the charge sequencer.
  Assumes lcs_map.svh is available on the include path.
*/
`include "lcs_map.svh"

package lcs_pkg;

  // Charge phases, one-hot
  typedef enum logic [5:0] {
    LCS_OFF     = 6'b000001,
    LCS_TRICKLE = 6'b000010,
    LCS_CC      = 6'b000100,
    LCS_CV      = 6'b001000,
    LCS_DONE    = 6'b010000,
    LCS_TOFAULT = 6'b100000
  } lcs_state_t;

  // Timer build options
  typedef enum logic [1:0] {
    LCS_OPT_PIN    = 2'h0,
    LCS_OPT_ALWAYS = 2'h1,
    LCS_OPT_NONE   = 2'h2
  } lcs_opt_t;

  // Current request levels
  typedef enum logic [1:0] {
    LCS_I_NONE   = 2'h0,
    LCS_I_TENTH  = 2'h1,
    LCS_I_FULL   = 2'h2,
    LCS_I_REDUCE = 2'h3
  } lcs_ireq_t;

endpackage : lcs_pkg

// ### lcs_seq.sv
/*
  Charge sequencer for a single-cell lithium charger: phase control,
  charge timer, status and fault indications, AHB-Lite registers.
  Assumes comparator inputs from the analog front end, a power-on
  detector driving NRST_I, and outside pull-ups on open-drain pins.
*/
`timescale 1ns/1ps
`default_nettype none
`include "lcs_map.svh"

module lcs_seq (
  // Clock and reset
  input  wire logic             CLK_I,
  input  wire logic             NRST_I,
  // AHB-Lite slave
  input  wire logic             HSEL_I,
  input  wire logic [11:0]      HADDR_I,
  input  wire logic [1:0]       HTRANS_I,
  input  wire logic             HWRITE_I,
  input  wire logic [2:0]       HSIZE_I,
  input  wire logic [31:0]      HWDATA_I,
  input  wire logic             HREADY_I,
  output logic [31:0]           HRDATA_O,
  output logic                  HREADYOUT_O,
  output logic                  HRESP_O,
  // Comparators and pins
  input  wire logic             EN_I,
  input  wire logic             LIMIT_ENABLE_INPUT_I,
  input  wire logic             VBAT_ABOVE_MIN_I,
  input  wire logic             VBAT_AT_FINAL_I,
  input  wire logic             VBAT_BELOW_RCH_I,
  input  wire logic             IBAT_BELOW_PROG_I,
  input  wire logic             IBAT_BELOW_TENTH_I,
  input  wire logic             DIE_HOT_I,
  input  wire logic             TEMP_OUT_WINDOW_I,
  input  wire logic             HEADROOM_OK_I,
  input  wire logic             ADAPTER_I,
  // Charge control and indications
  output lcs_pkg::lcs_ireq_t    IREQ_O,
  output logic                  CV_MODE_O,
  output logic                  STATUS_OE_O,
  output logic                  FAULT_OE_O,
  output logic                  ADAPTER_PRESENT_OUTPUT_O
);
  import lcs_pkg::*;

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  localparam int NS = 11;
  logic [NS-1:0] raw_in;
  logic [NS-1:0] sync1_reg;
  logic [NS-1:0] sync2_reg;

  assign raw_in = {EN_I, LIMIT_ENABLE_INPUT_I, VBAT_ABOVE_MIN_I,
                   VBAT_AT_FINAL_I, VBAT_BELOW_RCH_I, IBAT_BELOW_PROG_I,
                   IBAT_BELOW_TENTH_I, DIE_HOT_I, TEMP_OUT_WINDOW_I,
                   HEADROOM_OK_I, ADAPTER_I};

  // Two flops per input
  always_ff @(posedge CLK_I) begin
    if (!NRST_I) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= raw_in;
      sync2_reg <= sync1_reg;
    end
  end

  logic en_s, limit_enable_input_s, above_min_s, at_final_s, below_rch_s;
  logic ib_prog_s, ib_tenth_s, hot_s, temp_bad_s, head_s, adp_s;
  assign {en_s, limit_enable_input_s, above_min_s, at_final_s, below_rch_s,
          ib_prog_s, ib_tenth_s, hot_s, temp_bad_s, head_s,
          adp_s} = sync2_reg;

  // ----------------------------------------------------------------
  // AHB-Lite register slave
  // ----------------------------------------------------------------
  logic [31:0] ctrl_reg;
  logic [31:0] oscdiv_reg;
  logic        wr_pend_reg;
  logic [11:0] wr_addr_reg;
  logic        addr_ph;
  logic [31:0] rd_data;

  assign addr_ph = HSEL_I && HTRANS_I[1] && HREADY_I;

  // Capture write address phase
  always_ff @(posedge CLK_I) begin
    if (!NRST_I) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 12'h000;
    end else begin
      wr_pend_reg <= addr_ph && HWRITE_I;
      if (addr_ph) begin
        wr_addr_reg <= HADDR_I;
      end
    end
  end

  // Write data phase
  always_ff @(posedge CLK_I) begin
    if (!NRST_I) begin
      ctrl_reg   <= `LCS_CTRL_RESET;
      oscdiv_reg <= `LCS_OSCDIV_RESET;
    end else if (wr_pend_reg) begin
      if (wr_addr_reg == `LCS_CTRL_ADDR) begin
        ctrl_reg <= {27'h0, HWDATA_I[4:0]};
      end
      if (wr_addr_reg == `LCS_OSCDIV_ADDR) begin
        oscdiv_reg <= HWDATA_I;
      end
    end
  end

  // ----------------------------------------------------------------
  // Oscillator period divider
  // ----------------------------------------------------------------
  logic [31:0] osc_cnt_reg;
  logic        osc_tick;
  assign osc_tick = (osc_cnt_reg == 32'h0);

  // One-cycle enable each oscillator period
  always_ff @(posedge CLK_I) begin
    if (!NRST_I || !en_s) begin
      osc_cnt_reg <= `LCS_OSCDIV_RESET;
    end else if (osc_tick) begin
      osc_cnt_reg <= oscdiv_reg;
    end else begin
      osc_cnt_reg <= osc_cnt_reg - 32'h1;
    end
  end

  // ----------------------------------------------------------------
  // Enable and option decode
  // ----------------------------------------------------------------
  logic     enable;
  logic     en_d_reg;
  logic     en_rise;
  lcs_opt_t opt;
  logic     term_pin;
  logic     fast_lim_on;
  logic     trk_lim_on;
  logic     eoc_cur;

  assign enable   = en_s && ctrl_reg[`LCS_CTRL_EN_BIT];
  assign en_rise  = enable && !en_d_reg;
  assign opt      = lcs_opt_t'(ctrl_reg[`LCS_CTRL_OPT_LSB+1:
                                        `LCS_CTRL_OPT_LSB]);
  assign term_pin = ctrl_reg[`LCS_CTRL_TERM_BIT];
  assign trk_lim_on  = (opt != LCS_OPT_NONE);
  assign fast_lim_on = (opt == LCS_OPT_ALWAYS) ||
                       ((opt == LCS_OPT_PIN) && limit_enable_input_s &&
                        ctrl_reg[`LCS_CTRL_LIMIT_ENABLE_INPUT_BIT]);
  assign eoc_cur = term_pin ? ib_prog_s : ib_tenth_s;

  // Enable edge tracking
  always_ff @(posedge CLK_I) begin
    if (!NRST_I) begin
      en_d_reg <= 1'b0;
    end else begin
      en_d_reg <= enable;
    end
  end

  // ----------------------------------------------------------------
  // Charge phase state machine
  // ----------------------------------------------------------------
  lcs_state_t st_reg;
  lcs_state_t st_next;
  logic [`LCS_TIMER_W-1:0] tmr_reg;
  logic trk_exp;
  logic fast_exp;
  logic eoc_del_reg;
  logic rch_del_reg;

  assign trk_exp  = (tmr_reg >= `LCS_TRICKLE_LIMIT);
  assign fast_exp = (tmr_reg == `LCS_FAST_LIMIT) && osc_tick;

  // Next phase
  always_comb begin
    st_next = st_reg;
    unique case (st_reg)
      LCS_OFF: begin
        if (en_rise) begin
          st_next = above_min_s ? LCS_CC : LCS_TRICKLE;
        end
      end
      LCS_TRICKLE: begin
        if (trk_lim_on && trk_exp) begin
          st_next = LCS_TOFAULT;
        end else if (above_min_s) begin
          st_next = LCS_CC;
        end
      end
      LCS_CC: begin
        if (fast_lim_on && fast_exp) begin
          st_next = LCS_TOFAULT;
        end else if (at_final_s) begin
          st_next = LCS_CV;
        end
      end
      LCS_CV: begin
        if (fast_lim_on && fast_exp) begin
          st_next = LCS_TOFAULT;
        end else if (eoc_del_reg) begin
          st_next = LCS_DONE;
        end
      end
      LCS_DONE: begin
        if (rch_del_reg) begin
          st_next = LCS_CV;
        end
      end
      LCS_TOFAULT: begin
        st_next = LCS_TOFAULT;
      end
      default: st_next = LCS_OFF;
    endcase
  end

  // Phase register; enable low shuts charging down
  always_ff @(posedge CLK_I) begin
    if (!NRST_I) begin
      st_reg <= LCS_OFF;
    end else if (!enable) begin
      st_reg <= LCS_OFF;
    end else if (!temp_bad_s) begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------
  // Charge timer
  // ----------------------------------------------------------------
  logic phase_entry;
  assign phase_entry = (st_next != st_reg) &&
                       ((st_next == LCS_TRICKLE) || (st_next == LCS_CC));

  // Counts oscillator periods, frozen on window fault
  always_ff @(posedge CLK_I) begin
    if (!NRST_I || !enable) begin
      tmr_reg <= '0;
    end else if (phase_entry && !temp_bad_s) begin
      tmr_reg <= '0;
    end else if (osc_tick && !temp_bad_s &&
                 tmr_reg != `LCS_FAST_LIMIT) begin
      tmr_reg <= tmr_reg + 22'h1;
    end
  end

  // ----------------------------------------------------------------
  // Status filter: condition must hold from one oscillator tick to the next
  // ----------------------------------------------------------------
  logic eoc_arm_reg;
  logic rch_arm_reg;

  // Arm on condition, confirm at next tick
  always_ff @(posedge CLK_I) begin
    if (!NRST_I || !enable) begin
      eoc_arm_reg <= 1'b0;
      rch_arm_reg <= 1'b0;
      eoc_del_reg <= 1'b0;
      rch_del_reg <= 1'b0;
    end else begin
      if (!(st_reg == LCS_CV && eoc_cur)) begin
        eoc_arm_reg <= 1'b0;
        eoc_del_reg <= 1'b0;
      end else if (osc_tick) begin
        eoc_arm_reg <= 1'b1;
        eoc_del_reg <= eoc_arm_reg;
      end
      if (!(st_reg == LCS_DONE && below_rch_s)) begin
        rch_arm_reg <= 1'b0;
        rch_del_reg <= 1'b0;
      end else if (osc_tick) begin
        rch_arm_reg <= 1'b1;
        rch_del_reg <= rch_arm_reg;
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  logic charging;
  assign charging = (st_reg == LCS_TRICKLE) || (st_reg == LCS_CC) ||
                    (st_reg == LCS_CV) || (st_reg == LCS_DONE);

  // Current request and indications
  always_ff @(posedge CLK_I) begin
    if (!NRST_I) begin
      IREQ_O      <= LCS_I_NONE;
      CV_MODE_O   <= 1'b0;
      STATUS_OE_O <= 1'b0;
      FAULT_OE_O  <= 1'b0;
      ADAPTER_PRESENT_OUTPUT_O <= 1'b0;
    end else begin
      if (!charging || temp_bad_s || !head_s) begin
        IREQ_O <= LCS_I_NONE;
      end else if (hot_s) begin
        IREQ_O <= LCS_I_REDUCE;
      end else if (st_reg == LCS_TRICKLE) begin
        IREQ_O <= LCS_I_TENTH;
      end else begin
        IREQ_O <= LCS_I_FULL;
      end
      CV_MODE_O   <= (st_reg == LCS_CV) || (st_reg == LCS_DONE);
      STATUS_OE_O <= charging && (st_reg != LCS_DONE);
      FAULT_OE_O  <= (st_reg == LCS_TOFAULT) ||
                     (enable && temp_bad_s);
      ADAPTER_PRESENT_OUTPUT_O <= adp_s;
    end
  end

  // ----------------------------------------------------------------
  // Read data and bus answer
  // ----------------------------------------------------------------
  // Read mux, decoded from the address phase so data stands next cycle
  always_comb begin
    rd_data = 32'h0;
    unique case (HADDR_I)
      `LCS_CTRL_ADDR:   rd_data = ctrl_reg;
      `LCS_STAT_ADDR:   rd_data = {22'h0, FAULT_OE_O, STATUS_OE_O,
                                   hot_s, temp_bad_s, st_reg};
      `LCS_TIMER_ADDR:  rd_data = {10'h0, tmr_reg};
      `LCS_OSCDIV_ADDR: rd_data = oscdiv_reg;
      default:          rd_data = 32'h0;
    endcase
  end

  // Zero wait state, always OKAY
  always_ff @(posedge CLK_I) begin
    if (!NRST_I) begin
      HRDATA_O    <= 32'h0;
      HREADYOUT_O <= 1'b1;
      HRESP_O     <= 1'b0;
    end else begin
      HREADYOUT_O <= 1'b1;
      HRESP_O     <= 1'b0;
      if (addr_ph && !HWRITE_I) begin
        HRDATA_O <= rd_data;
      end
    end
  end

endmodule // lcs_seq
`default_nettype wire

// ### lcs_seq_monitor.sv
/*
  Port checker of the charge sequencer, bound to lcs_seq.
  Assumes lcs_pkg is compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module lcs_seq_mon (
  // Clock and reset
  input wire logic               CLK_I,
  input wire logic               NRST_I,
  // Inputs
  input wire logic               EN_I,
  input wire logic               VBAT_ABOVE_MIN_I,
  input wire logic               VBAT_AT_FINAL_I,
  input wire logic               DIE_HOT_I,
  input wire logic               TEMP_OUT_WINDOW_I,
  input wire logic               HEADROOM_OK_I,
  input wire logic               ADAPTER_I,
  // Outputs
  input wire logic               HREADYOUT_O,
  input wire logic               HRESP_O,
  input var  lcs_pkg::lcs_ireq_t IREQ_O,
  input wire logic               CV_MODE_O,
  input wire logic               STATUS_OE_O,
  input wire logic               FAULT_OE_O,
  input wire logic               ADAPTER_PRESENT_OUTPUT_O
);
  import lcs_pkg::*;
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!NRST_I);
  // Bus and charge control relations
  chk_bus_zero_wait: assert property (HREADYOUT_O && !HRESP_O)
    else $error("bus not ready or not okay");
  chk_en_off: assert property (
    !EN_I [*5] |=> IREQ_O == LCS_I_NONE && !STATUS_OE_O && !CV_MODE_O)
    else $error("charger on while disabled");
  chk_window_pause: assert property (
    (TEMP_OUT_WINDOW_I && EN_I) [*5] |=> FAULT_OE_O && IREQ_O == LCS_I_NONE)
    else $error("no pause on window fault");
  chk_headroom_off: assert property (
    !HEADROOM_OK_I [*5] |=> IREQ_O == LCS_I_NONE)
    else $error("charging without headroom");
  chk_adapter_follow: assert property (
    ADAPTER_I [*4] |=> ADAPTER_PRESENT_OUTPUT_O)
    else $error("adapter output not high");
  chk_trickle_exit: assert property (
    VBAT_ABOVE_MIN_I [*8] |-> ##[0:12] IREQ_O != LCS_I_TENTH)
    else $error("trickle kept above threshold");
  chk_fold_cause: assert property (
    $rose(IREQ_O == LCS_I_REDUCE) |-> $past(DIE_HOT_I, 3) || $past(DIE_HOT_I, 4))
    else $error("reduced current without hot die");
  chk_cv_cause: assert property (
    $rose(CV_MODE_O) |-> $past(VBAT_AT_FINAL_I, 3) || $past(VBAT_AT_FINAL_I, 4))
    else $error("voltage mode before final level");
endmodule // lcs_seq_mon
bind lcs_seq lcs_seq_mon u_chk (.CLK_I(CLK_I), .NRST_I(NRST_I), .EN_I(EN_I),
  .VBAT_ABOVE_MIN_I(VBAT_ABOVE_MIN_I), .VBAT_AT_FINAL_I(VBAT_AT_FINAL_I),
  .DIE_HOT_I(DIE_HOT_I), .TEMP_OUT_WINDOW_I(TEMP_OUT_WINDOW_I),
  .HEADROOM_OK_I(HEADROOM_OK_I), .ADAPTER_I(ADAPTER_I),
  .HREADYOUT_O(HREADYOUT_O), .HRESP_O(HRESP_O), .IREQ_O(IREQ_O),
  .CV_MODE_O(CV_MODE_O), .STATUS_OE_O(STATUS_OE_O), .FAULT_OE_O(FAULT_OE_O),
  .ADAPTER_PRESENT_OUTPUT_O(ADAPTER_PRESENT_OUTPUT_O));
`default_nettype wire

// ### tb.sv
/*
  Self-checking bench of lcs_seq with a battery model.
  Assumes lcs_pkg, lcs_batt and lcs_seq_monitor are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`include "lcs_map.svh"
module tb;
  import lcs_pkg::*;
  logic             clk, rst_n, hsel, hwrite, en, hot, temp, head;
  logic             adapt, load, sel_prog, limit_enable_input;
  logic [1:0]       htrans;
  logic [2:0]       hsize;
  logic [7:0]       load_val;
  logic [11:0]      haddr;
  logic [31:0]      hwdata, rd;
  wire logic [31:0] hrdata;
  wire logic        hready, hresp, cv, st_oe, flt_oe, apo;
  wire logic        amin, afin, brch, taper, st_pin, flt_pin;
  lcs_ireq_t        ireq;
  int               error_cnt, cmp_count;
  lcs_seq u_lcs_seq (.CLK_I(clk), .NRST_I(rst_n), .HSEL_I(hsel),
    .HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(hsize),
    .HWDATA_I(hwdata), .HREADY_I(hready), .HRDATA_O(hrdata),
    .HREADYOUT_O(hready), .HRESP_O(hresp), .EN_I(en),
    .LIMIT_ENABLE_INPUT_I(limit_enable_input), .VBAT_ABOVE_MIN_I(amin),
    .VBAT_AT_FINAL_I(afin), .VBAT_BELOW_RCH_I(brch),
    .IBAT_BELOW_PROG_I(taper && sel_prog),
    .IBAT_BELOW_TENTH_I(taper && !sel_prog), .DIE_HOT_I(hot),
    .TEMP_OUT_WINDOW_I(temp), .HEADROOM_OK_I(head), .ADAPTER_I(adapt),
    .IREQ_O(ireq), .CV_MODE_O(cv), .STATUS_OE_O(st_oe),
    .FAULT_OE_O(flt_oe), .ADAPTER_PRESENT_OUTPUT_O(apo));
  lcs_batt u_lcs_batt (.clk_i(clk), .rst_n_i(rst_n), .ireq_i(ireq),
    .cv_i(cv), .status_oe_i(st_oe), .fault_oe_i(flt_oe), .load_i(load),
    .load_val_i(load_val), .above_min_o(amin), .at_final_o(afin),
    .below_rch_o(brch), .taper_o(taper), .status_pin_o(st_pin),
    .fault_pin_o(flt_pin));
  // ----------
  // Helpers
  // ----------
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [31:0] s, e);
    cmp_count++;
    if (s !== e) begin
      error_cnt++;
      $display("BAD %s exp %h seen %h", nm, e, s);
    end
  endtask
  // Expected current request from battery and die state
  function automatic lcs_ireq_t want(input logic trk, hot_die);
    if (hot_die) return LCS_I_REDUCE;
    return trk ? LCS_I_TENTH : LCS_I_FULL;
  endfunction
  function automatic logic [1:0] probe(input int k);
    case (k)
      0: probe = ireq;
      1: probe = {1'b0, !st_pin};
      2: probe = {1'b0, !flt_pin};
      3: probe = {1'b0, cv};
      default: probe = {1'b0, apo};
    endcase
  endfunction
  task automatic await(input string nm, input int k, input logic [1:0] v);
    int n;
    n = 0;
    while (probe(k) !== v && n < 3000) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(nm, probe(k), v);
  endtask
  // One single AHB-Lite word transfer
  task automatic ahb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    rd = hrdata;
  endtask
  task automatic charge_to(input logic [7:0] v);
    @(posedge clk);
    load <= 1'b1;
    load_val <= v;
    @(posedge clk);
    load <= 1'b0;
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // ----------
  // Tests
  // ----------
  initial begin
    #5_000_000;
    error_cnt++;
    tally_and_finish;
  end
  initial begin
    void'($urandom(32'hD514));
    {hsel, hwrite, htrans, haddr, hwdata, rd, load, load_val} = '0;
    {en, hot, temp, adapt, rst_n, error_cnt, cmp_count} = '0;
    hsize = 3'h2;
    head = 1'b1;
    sel_prog = 1'b1;
    limit_enable_input = 1'($urandom);
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1;
    chk("ireq", ireq, LCS_I_NONE);
    chk("status", st_pin, 1'b1);
    ahb(1'b0, 12'hFF0, 32'h0);
    chk("unmapped", rd, 32'h0);
    ahb(1'b0, `LCS_OSCDIV_ADDR, 32'h0);
    chk("oscdiv", rd, `LCS_OSCDIV_RESET);
    ahb(1'b1, 12'h000, 32'h0000_0013);
    ahb(1'b0, 12'h000, 32'h0);
    chk("ctrl", rd, 32'h0000_0013);
    en <= 1'b1;
    await("trickle", 0, want(1'b1, 1'b0));
    await("cc", 0, want(1'b0, 1'b0));
    await("cv", 3, 2'h1);
    await("eoc", 1, 2'h0);
    repeat (60) @(posedge clk);
    chk("keep", ireq !== LCS_I_NONE, 1'b1);
    charge_to(8'($urandom_range(170, 100)));
    await("recharge", 1, 2'h1);
    ahb(1'b1, 12'h000, 32'h0000_0003);
    repeat (800) @(posedge clk);
    chk("no eoc", !st_pin, 1'b1);
    sel_prog <= 1'b0;
    await("eoc tenth", 1, 2'h0);
    hot <= 1'b1;
    await("fold", 0, want(1'b0, 1'b1));
    hot <= 1'b0;
    temp <= 1'b1;
    await("window", 2, 2'h1);
    chk("paused", ireq, LCS_I_NONE);
    temp <= 1'b0;
    await("window off", 2, 2'h0);
    head <= 1'b0;
    await("headroom", 0, LCS_I_NONE);
    head <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      adapt <= 1'($urandom);
      repeat (1 + $urandom_range(5)) @(posedge clk);
      await("adapter", 4, {1'b0, adapt});
    end
    @(posedge clk);
    en <= 1'b0;
    await("off", 0, LCS_I_NONE);
    await("off status", 1, 2'h0);
    charge_to(8'h0A);
    en <= 1'b1;
    await("restart", 0, want(1'b1, 1'b0));
    tally_and_finish;
  end
endmodule // tb
`default_nettype wire
